/* File: rtl/msq_null_seek.sv */
// Purpose: Compares setpoint with motor position and drives toward null
// Assumes: Inputs are already in the clock domain
// Notes: Drive outputs are registered and cleared when disabled

`timescale 1ns/1ps

module msq_null_seek (
    input wire logic clock, // 200 MHz clock
    input wire logic rstn, // Synchronised reset, active low
    input wire logic enable, // Motor supply present
    input wire logic [msq_pkg::POS_W-1:0] setpoint, // Target position
    input wire logic [msq_pkg::POS_W-1:0] feedback, // Motor position
    output msq_pkg::msq_drive_t drive, // Motor direction
    output logic atNull // Inside deadband
);
    import msq_pkg::*;

    logic [POS_W:0] fbWide;
    logic [POS_W:0] spWide;
    logic fbHigh;
    logic spHigh;
    msq_drive_t drive_q;
    msq_drive_t drive_d;

    // ----------------------------------------
    // Decision with deadband
    // ----------------------------------------
    // Extra bit keeps the margin sums from wrapping
    assign fbWide = {1'b0, feedback};
    assign spWide = {1'b0, setpoint};
    assign fbHigh = fbWide > (spWide + {1'b0, NULL_DEADBAND});
    assign spHigh = spWide > (fbWide + {1'b0, NULL_DEADBAND});

    // Inside the band the motor rests until setpoint moves
    always_comb begin
        drive_d = '0;
        if (enable) begin
            drive_d.forward = fbHigh;
            drive_d.reverse = spHigh;
        end
    end

    // Registered drive
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    assign drive = drive_q;
    assign atNull = !fbHigh && !spHigh;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_FORWARD_WHEN_HIGH: assert property (@(posedge clock) disable iff (!rstn)
        enable && fbHigh |=> drive.forward && !drive.reverse)
        else $error("forward drive missing");
    AST_REVERSE_WHEN_LOW: assert property (@(posedge clock) disable iff (!rstn)
        enable && spHigh |=> drive.reverse && !drive.forward)
        else $error("reverse drive missing");
    AST_REST_IN_BAND: assert property (@(posedge clock) disable iff (!rstn)
        (feedback <= setpoint + NULL_DEADBAND) && (setpoint <= feedback + NULL_DEADBAND)
        && setpoint < 10'h3F0 && feedback < 10'h3F0 |=> drive == '0)
        else $error("drive inside deadband");
    AST_NO_DRIVE_DISABLED: assert property (@(posedge clock) disable iff (!rstn)
        !enable |=> drive == '0)
        else $error("drive without supply");
    AST_REST_AT_NULL: assert property (@(posedge clock) disable iff (!rstn)
        atNull |=> drive == '0)
        else $error("drive at null");

endmodule // msq_null_seek

/* File: rtl/msq_pkg.sv */
// Purpose: Shared types and constants for the mass change sequencer
// Assumes: Position feedback arrives as an unsigned digital word
// Notes: Position scale is in feedback counts

package msq_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int POS_W = 10;
    localparam int CNT_W = 3;

    // ----------------------------------------
    // Counter states, caged is zero
    // ----------------------------------------
    localparam logic [CNT_W-1:0] STATE_CAGED = 3'h0;
    localparam logic [CNT_W-1:0] STATE_LAST = 3'h4;
    localparam logic [CNT_W-1:0] STATE_ONE_STEP = 3'h1;
    localparam logic [CNT_W-1:0] STATE_ALL_ON = 3'h1;

    // ----------------------------------------
    // Setpoint scale, binary weights start at bit 7
    // ----------------------------------------
    localparam int STATE_LSB = 7;
    localparam logic [POS_W-1:0] SETPOINT_OFFSET = 10'h040;
    localparam logic [POS_W-1:0] BACKOFF_STEP = 10'h010;
    localparam logic [POS_W-1:0] HALF_SLOT = 10'h020;
    localparam logic [POS_W-1:0] NULL_DEADBAND = 10'h002;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic powerOn;
        logic powerOff;
        logic preset;
        logic increment;
    } msq_cmd_t;

    typedef struct packed {
        logic forward;
        logic reverse;
    } msq_drive_t;

    typedef enum logic {
        PWR_OFF,
        PWR_ON
    } msq_pwr_t;

endpackage

/* File: rtl/msq_sequencer.sv */
// Purpose: Mass change sequencer, counter, setpoint and motor drive
// Assumes: Command pins are asynchronous pulses, active high
// Notes: Command edges step the logic; the system clock only samples

`timescale 1ns/1ps

module msq_sequencer (
    input wire logic clock, // 200 MHz clock
    input wire logic resetn, // Async reset, active low
    input wire logic unitPowerOnCommand, // Power on pulse
    input wire logic unitPowerOffCommand, // Power off pulse
    input wire logic sequencerPresetCommand, // Preset pulse
    input wire logic incrementCommand, // Step pulse
    input wire logic heaterControlOn, // Heater control level
    input wire logic [msq_pkg::POS_W-1:0] positionFeedback, // Pot position
    output logic unitPoweredStatus, // Powered status
    output logic motorSupplyEnable, // Motor supply switch
    output msq_pkg::msq_drive_t motorDrive, // Motor direction
    output logic [msq_pkg::CNT_W-1:0] massState, // Basic state
    output logic reversalActive, // In reversal substate
    output logic reversalDecode, // Decode flip-flop
    output logic [msq_pkg::POS_W-1:0] positionSetpoint // Target
);
    import msq_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [1:0] rstSync_q;
    logic rstn;
    msq_cmd_t cmdRaw;
    msq_cmd_t cmdMeta_q;
    msq_cmd_t cmdSync_q;
    msq_cmd_t cmdPrev_q;
    msq_cmd_t cmdEdge;
    logic heaterMeta_q;
    logic heaterSync_q;
    logic [POS_W-1:0] fbMeta_q;
    logic [POS_W-1:0] fbSync_q;
    msq_pwr_t pwrState_q;
    logic powered;
    logic stepEvent;
    logic div2_q;
    logic [CNT_W-1:0] massCount_q;
    logic decode_q;
    logic backoff_q;
    logic travelDown_q;
    logic supply_q;
    logic [POS_W-1:0] setpoint_q;
    logic [POS_W-1:0] setpoint_d;
    logic [POS_W-1:0] baseSetpoint;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Five-state count, wrapping last back to caged
    function automatic logic [CNT_W-1:0] nextCount(
        input logic [CNT_W-1:0] cur
    );
        logic [CNT_W-1:0] nxt;
        nxt = cur + STATE_ONE_STEP;
        if (cur >= STATE_LAST) begin
            nxt = STATE_CAGED;
        end
        return nxt;
    endfunction

    // JK flip-flop next value
    function automatic logic jkNext(
        input logic j,
        input logic k,
        input logic q
    );
        return (j && !q) || (!k && q);
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Async assert, synchronous release
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    assign rstn = rstSync_q[1];

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    assign cmdRaw.powerOn = unitPowerOnCommand;
    assign cmdRaw.powerOff = unitPowerOffCommand;
    assign cmdRaw.preset = sequencerPresetCommand;
    assign cmdRaw.increment = incrementCommand;

    // Two flops per command, third for edge detection
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmdMeta_q <= '0;
            cmdSync_q <= '0;
            cmdPrev_q <= '0;
        end else begin
            cmdMeta_q <= cmdRaw;
            cmdSync_q <= cmdMeta_q;
            cmdPrev_q <= cmdSync_q;
        end
    end

    assign cmdEdge = msq_cmd_t'(cmdSync_q & ~cmdPrev_q);

    // Heater level and feedback word
    // Feedback moves slowly, so a torn word costs one cycle only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            heaterMeta_q <= 1'b0;
            heaterSync_q <= 1'b0;
            fbMeta_q <= '0;
            fbSync_q <= '0;
        end else begin
            heaterMeta_q <= heaterControlOn;
            heaterSync_q <= heaterMeta_q;
            fbMeta_q <= positionFeedback;
            fbSync_q <= fbMeta_q;
        end
    end

    // ----------------------------------------
    // Power control
    // ----------------------------------------
    // Off wins if both pulses land together
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pwrState_q <= PWR_OFF;
        end else begin
            case (pwrState_q)
                PWR_OFF: begin
                    if (cmdEdge.powerOn && !cmdEdge.powerOff) begin
                        pwrState_q <= PWR_ON;
                    end
                end
                PWR_ON: begin
                    if (cmdEdge.powerOff) begin
                        pwrState_q <= PWR_OFF;
                    end
                end
                default: begin
                    pwrState_q <= PWR_OFF;
                end
            endcase
        end
    end

    assign powered = (pwrState_q == PWR_ON);

    // Supply only with heater off
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            supply_q <= 1'b0;
        end else begin
            supply_q <= powered && !heaterSync_q;
        end
    end

    // ----------------------------------------
    // Step logic
    // ----------------------------------------
    // Increments only count while powered; preset takes priority
    assign stepEvent = cmdEdge.increment && powered && !cmdEdge.preset;

    // Divide-by-two and five-state counter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div2_q <= 1'b0;
            massCount_q <= STATE_CAGED;
        end else if (cmdEdge.preset) begin
            div2_q <= 1'b0;
            massCount_q <= STATE_CAGED;
        end else if (stepEvent) begin
            div2_q <= !div2_q;
            if (div2_q) begin
                massCount_q <= nextCount(massCount_q);
            end
        end
    end

    // Decode flip-flop, clocked with the divider
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            decode_q <= 1'b0;
        end else if (cmdEdge.preset) begin
            decode_q <= 1'b0;
        end else if (stepEvent) begin
            decode_q <= jkNext(div2_q, !massCount_q[0], decode_q);
        end
    end

    // Back-off extra only for the step out of caged
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            backoff_q <= 1'b0;
        end else if (cmdEdge.preset) begin
            backoff_q <= 1'b0;
        end else if (stepEvent && div2_q) begin
            backoff_q <= (massCount_q == STATE_CAGED);
        end
    end

    // Travel sense: down after reset, preset or wrap, up otherwise
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            travelDown_q <= 1'b1;
        end else if (cmdEdge.preset) begin
            travelDown_q <= 1'b1;
        end else if (stepEvent && div2_q) begin
            travelDown_q <= (massCount_q >= STATE_LAST);
        end
    end

    // ----------------------------------------
    // Setpoint
    // ----------------------------------------
    // Offset plus binary-weighted counter plus back-off extra
    always_comb begin
        baseSetpoint = SETPOINT_OFFSET;
        baseSetpoint = baseSetpoint + (POS_W'(massCount_q) << STATE_LSB);
        if (backoff_q) begin
            baseSetpoint = baseSetpoint + BACKOFF_STEP;
        end
    end

    // Substate backs away against the direction of travel
    always_comb begin
        setpoint_d = baseSetpoint;
        if (div2_q) begin
            if (travelDown_q) begin
                setpoint_d = baseSetpoint + HALF_SLOT;
            end else begin
                setpoint_d = baseSetpoint - HALF_SLOT;
            end
        end
    end

    // Registered so the comparator sees a clean word
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            setpoint_q <= SETPOINT_OFFSET;
        end else begin
            setpoint_q <= setpoint_d;
        end
    end

    // ----------------------------------------
    // Motor drive
    // ----------------------------------------
    msq_null_seek u_nullSeek (
        .clock(clock),
        .rstn(rstn),
        .enable(supply_q),
        .setpoint(setpoint_q),
        .feedback(fbSync_q),
        .drive(motorDrive),
        .atNull()
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign unitPoweredStatus = powered;
    assign motorSupplyEnable = supply_q;
    assign massState = massCount_q;
    assign reversalActive = div2_q;
    assign reversalDecode = decode_q;
    assign positionSetpoint = setpoint_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_COUNT_RANGE: assert property (@(posedge clock) disable iff (!rstn)
        massCount_q <= STATE_LAST)
        else $error("counter left five states");
    AST_PRESET_CAGES: assert property (@(posedge clock) disable iff (!rstn)
        cmdEdge.preset |=> massCount_q == STATE_CAGED && !div2_q && !decode_q)
        else $error("preset did not cage");
    AST_IDLE_UNPOWERED: assert property (@(posedge clock) disable iff (!rstn)
        cmdEdge.increment && !powered && !cmdEdge.preset |=> $stable(div2_q) && $stable(massCount_q))
        else $error("stepped while unpowered");
    AST_DIV2_TOGGLES: assert property (@(posedge clock) disable iff (!rstn)
        stepEvent |=> div2_q != $past(div2_q))
        else $error("divider did not toggle");
    AST_SUBSTATE_FIRST: assert property (@(posedge clock) disable iff (!rstn)
        stepEvent && !div2_q |=> $stable(massCount_q) && div2_q)
        else $error("basic state skipped substate");
    AST_WRAP_TO_CAGED: assert property (@(posedge clock) disable iff (!rstn)
        stepEvent && div2_q && massCount_q == STATE_LAST |=> massCount_q == STATE_CAGED && travelDown_q)
        else $error("wrap failed");
    AST_DECODE_SET: assert property (@(posedge clock) disable iff (!rstn)
        stepEvent && div2_q && massCount_q[0] |=> decode_q)
        else $error("decode not set");
    AST_BACKOFF_EXTRA: assert property (@(posedge clock) disable iff (!rstn)
        stepEvent && div2_q && massCount_q == STATE_CAGED |=> ##1 massCount_q == STATE_ALL_ON
        && setpoint_q == SETPOINT_OFFSET + (10'h001 << STATE_LSB) + BACKOFF_STEP)
        else $error("back-off extra missing");
    AST_CAGED_OFFSET: assert property (@(posedge clock) disable iff (!rstn)
        cmdEdge.preset |=> ##1 setpoint_q == SETPOINT_OFFSET)
        else $error("caged setpoint wrong");
    AST_SUPPLY_HEATER: assert property (@(posedge clock) disable iff (!rstn)
        heaterSync_q || !powered |=> !motorSupplyEnable)
        else $error("supply with heater on");
    AST_STATUS_OFF: assert property (@(posedge clock) disable iff (!rstn)
        cmdEdge.powerOff |=> !unitPoweredStatus)
        else $error("status stayed high");

endmodule // msq_sequencer

/* File: verification/msq_motor_model.sv */
// Purpose: Behavioural mass change motor with its position pot
// Assumes: Forward drive lowers the pot word, reverse raises it
// Notes: Moves one count per STEP_CLOCKS while supplied and driven

`timescale 1ns/1ps

module msq_motor_model import msq_pkg::*; #(
    parameter int STEP_CLOCKS = 8, // Slow gear train
    parameter logic [POS_W-1:0] START_POS = 10'h040 // Pot rest position
) (
    input wire logic clock, // Bench clock
    input wire logic resetn, // Places the pot at start and clears the step divider
    input wire logic supplyOn, // Motor supply switch
    input msq_pkg::msq_drive_t drive, // Direction from the block
    output logic [msq_pkg::POS_W-1:0] feedback // Pot wiper word
);
    int divCount;

    // --------------------------------------------
    // Mechanism
    // --------------------------------------------
    // Both directions at once stalls the motor rather than picking one
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            divCount <= 0;
            feedback <= START_POS;
        end else if (supplyOn && (drive.forward ^ drive.reverse)) begin
            divCount <= (divCount == STEP_CLOCKS - 1) ? 0 : divCount + 1;
            if (divCount == STEP_CLOCKS - 1) begin
                feedback <= drive.forward ? feedback - 10'h001 : feedback + 10'h001;
            end
        end else begin
            divCount <= 0; // Standstill, no creep
        end
    end
endmodule // msq_motor_model

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the mass change sequencer
// Assumes: Command pulses four clocks high and eight low
// Notes: Each step waits for the motor to settle at null

`timescale 1ns/1ps

module tb;
    import msq_pkg::*;

    localparam msq_cmd_t CMD_ON = 4'h8;
    localparam msq_cmd_t CMD_OFF = 4'h4;
    localparam msq_cmd_t CMD_PRE = 4'h2;
    localparam msq_cmd_t CMD_INC = 4'h1;

    logic clock = 1'b0;
    logic resetn = 1'b0;
    msq_cmd_t cmd = '0;
    logic heaterControlOn = 1'b0;
    logic [POS_W-1:0] positionFeedback;
    logic unitPoweredStatus;
    logic motorSupplyEnable;
    msq_drive_t motorDrive;
    logic [CNT_W-1:0] massState;
    logic reversalActive;
    logic reversalDecode;
    logic [POS_W-1:0] positionSetpoint;
    logic [CNT_W-1:0] expState = '0;
    logic expSub = 1'b0;
    logic expDec = 1'b0;
    int err_total = 0;
    int n_tests = 0;

    always #2.5 clock = ~clock;

    // --------------------------------------------
    // Block and partner
    // --------------------------------------------
    msq_sequencer i_dut (
        .clock(clock), .resetn(resetn), .unitPowerOnCommand(cmd.powerOn),
        .unitPowerOffCommand(cmd.powerOff), .sequencerPresetCommand(cmd.preset),
        .incrementCommand(cmd.increment), .heaterControlOn(heaterControlOn),
        .positionFeedback(positionFeedback), .unitPoweredStatus(unitPoweredStatus),
        .motorSupplyEnable(motorSupplyEnable), .motorDrive(motorDrive), .massState(massState),
        .reversalActive(reversalActive), .reversalDecode(reversalDecode),
        .positionSetpoint(positionSetpoint)
    );

    msq_motor_model i_motor (
        .clock(clock), .resetn(resetn), .supplyOn(motorSupplyEnable), .drive(motorDrive),
        .feedback(positionFeedback)
    );

    // --------------------------------------------
    // Helpers
    // --------------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Lands one step past the edge so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic pulse(input msq_cmd_t c);
        @(posedge clock);
        cmd <= c;
        repeat (4) @(posedge clock);
        cmd <= '0;
        tick(8);
    endtask

    function automatic logic [POS_W-1:0] expSetpoint(input logic [CNT_W-1:0] s, input logic sub);
        logic [POS_W-1:0] v;
        v = SETPOINT_OFFSET + (POS_W'(s) << STATE_LSB);
        if (s == STATE_ALL_ON) v = v + BACKOFF_STEP;
        if (sub) v = (s == STATE_CAGED) ? v + HALF_SLOT : v - HALF_SLOT;
        return v;
    endfunction

    task automatic seek_null();
        logic [POS_W-1:0] sp;
        logic [POS_W-1:0] fb;
        int i;
        sp = positionSetpoint;
        fb = positionFeedback;
        if (fb > sp + 10'h008) check(POS_W'({motorDrive.forward, motorDrive.reverse}), 10'h002);
        if (sp > fb + 10'h008) check(POS_W'({motorDrive.forward, motorDrive.reverse}), 10'h001);
        i = 0;
        while (motorDrive !== 2'b00 && i < 6000) begin
            tick(1);
            i++;
        end
        if (i >= 6000) begin
            err_total++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, motorDrive, 2'b00);
            print_verdict();
        end else begin
            tick(40);
            check(POS_W'({motorDrive.forward, motorDrive.reverse}), 10'h000);
            fb = positionFeedback;
            check(POS_W'((fb > sp + NULL_DEADBAND + 1) || (sp > fb + NULL_DEADBAND + 1)), 10'h000);
        end
    endtask

    task automatic step();
        logic d;
        d = (expSub & ~expDec) | (expState[0] & expDec); // JK with K the inverted LSB
        if (expSub) expState = (expState == STATE_LAST) ? STATE_CAGED : expState + STATE_ONE_STEP;
        expSub = ~expSub;
        expDec = d;
        pulse(CMD_INC);
        check(POS_W'(massState), POS_W'(expState));
        check(POS_W'(reversalActive), POS_W'(expSub));
        check(POS_W'(reversalDecode), POS_W'(expDec));
        check(positionSetpoint, expSetpoint(expState, expSub));
        seek_null();
    endtask

    // --------------------------------------------
    // Scenarios
    // --------------------------------------------
    task automatic t_reset();
        check(POS_W'(unitPoweredStatus), 10'h000);
        check(POS_W'(motorSupplyEnable), 10'h000);
        check(POS_W'(massState), POS_W'(STATE_CAGED));
        check(positionSetpoint, SETPOINT_OFFSET);
    endtask

    task automatic t_unpowered();
        pulse(CMD_INC);
        check(POS_W'(massState), POS_W'(STATE_CAGED));
        check(POS_W'(reversalActive), 10'h000);
    endtask

    task automatic t_power();
        pulse(CMD_ON);
        check(POS_W'(unitPoweredStatus), 10'h001);
        check(POS_W'(motorSupplyEnable), 10'h001);
        @(posedge clock);
        heaterControlOn <= 1'b1;
        tick(8);
        check(POS_W'(motorSupplyEnable), 10'h000);
        check(POS_W'(unitPoweredStatus), 10'h001);
        @(posedge clock);
        heaterControlOn <= 1'b0;
        tick(8);
        check(POS_W'(motorSupplyEnable), 10'h001);
    endtask

    task automatic t_preset(input msq_cmd_t c);
        pulse(c);
        expState = STATE_CAGED;
        expSub = 1'b0;
        expDec = 1'b0;
        check(POS_W'(massState), POS_W'(STATE_CAGED));
        check(POS_W'(reversalActive), 10'h000);
        check(POS_W'(reversalDecode), 10'h000);
        check(positionSetpoint, SETPOINT_OFFSET);
        seek_null();
    endtask

    // Full cycle through every state and substate, then wrap
    task automatic t_sequence();
        repeat (10) step();
    endtask

    // Preset landing with an increment, mid-way out of state one
    task automatic t_preset_mid();
        repeat (3) step();
        t_preset(CMD_PRE | CMD_INC);
        step();
    endtask

    task automatic t_power_off();
        pulse(CMD_OFF);
        check(POS_W'(unitPoweredStatus), 10'h000);
        check(POS_W'(motorSupplyEnable), 10'h000);
        // On and off together: off must win
        pulse(CMD_ON | CMD_OFF);
        check(POS_W'(unitPoweredStatus), 10'h000);
        pulse(CMD_INC);
        check(POS_W'(massState), POS_W'(expState));
        check(POS_W'(reversalActive), POS_W'(expSub));
    endtask

    // --------------------------------------------
    // Main sequence
    // --------------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        tick(4);
        t_reset();
        t_unpowered();
        t_power();
        t_preset(CMD_PRE);
        t_sequence();
        t_preset_mid();
        t_power_off();
        print_verdict();
    end
endmodule // tb
